// ---- sar_adc_readout.sv ----
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// result fifo
// ----------------------------------------------------------------------
module sar_result_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    wire push = in_valid_in && in_ready_out;
    wire pop = out_valid_out && out_ready_in;
    wire empty = (wr_q == rd_q);
    wire full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);

    assign in_ready_out = !full;
    assign out_valid_out = !empty;
    assign out_data_out = mem[rd_q[AW-1:0]];

    always_ff @(posedge ref_clk_in) begin
        if (push) begin
            mem[wr_q[AW-1:0]] <= in_data_in;
        end
    end

    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= wr_q + (AW+1)'(push);
            rd_q <= rd_q + (AW+1)'(pop);
        end
    end
endmodule

// ----------------------------------------------------------------------
// conversion control and parallel readout
// ----------------------------------------------------------------------
module sar_adc_readout (
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    input wire logic cs_n_in,
    input wire logic rd_n_in,
    input wire logic convert_start_n_in,
    input wire logic half_sel_in,
    input wire logic [sar_pkg::RESULT_W-1:0] sample_in,
    output logic busy_out,
    output logic [sar_pkg::RESULT_W-1:0] result_bus_out,
    output logic result_bus_oe_out
);
    import sar_pkg::*;

    localparam int PW = RESULT_W + 4;
    localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYCLES - 1);
    localparam logic [CNT_W-1:0] ACQ_LAST = CNT_W'(ACQ_CYCLES - 1);

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [PW-1:0] pin_meta_q;
    logic [PW-1:0] pin_sync_q;
    logic cnv_prev_q;

    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            // each flop resets to its pin's idle level, half select idles low,
            // so the lanes do not swap for a cycle after reset
            pin_meta_q <= {4'he, RESULT_RESET};
            pin_sync_q <= {4'he, RESULT_RESET};
            cnv_prev_q <= 1'b1;
        end else begin
            pin_meta_q <= {cs_n_in, rd_n_in, convert_start_n_in, half_sel_in, sample_in};
            pin_sync_q <= pin_meta_q;
            cnv_prev_q <= pin_sync_q[PW-3];
        end
    end

    wire cs_s = !pin_sync_q[PW-1];
    wire rd_s = !pin_sync_q[PW-2];
    wire cnv_n_s = pin_sync_q[PW-3];
    wire half_s = pin_sync_q[PW-4];
    wire [RESULT_W-1:0] sample_s = pin_sync_q[RESULT_W-1:0];

    // ------------------------------------------------------------------
    // conversion sequencer
    // ------------------------------------------------------------------
    conv_state_t state_q;
    conv_state_t state_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [RESULT_W-1:0] hold_q;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [RESULT_W-1:0] fifo_out_data;

    wire cnv_fall = cnv_prev_q && !cnv_n_s;
    // a full fifo refuses the start, so every finished result is written into the fifo
    wire start = (state_q == ST_IDLE) && cnv_fall && cs_s && fifo_in_ready;
    wire cnt_done = (cnt_q == '0);
    wire fifo_push = (state_q == ST_CONV) && cnt_done;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        unique case (state_q)
            ST_IDLE: begin
                if (start) begin
                    state_d = ST_CONV;
                    cnt_d = CONV_LAST;
                end
            end
            ST_CONV: begin
                cnt_d = cnt_q - CNT_W'(1);
                if (cnt_done) begin
                    state_d = ST_ACQ;
                    cnt_d = ACQ_LAST;
                end
            end
            ST_ACQ: begin
                cnt_d = cnt_q - CNT_W'(1);
                if (cnt_done) begin
                    state_d = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            // reset is never qualified by chip select
            state_q <= ST_ACQ;
            cnt_q <= ACQ_LAST;
            busy_out <= 1'b0;
            hold_q <= RESULT_RESET;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            busy_out <= (state_d == ST_CONV);
            if (start) begin
                hold_q <= sample_s;
            end
        end
    end

    // ------------------------------------------------------------------
    // result buffering and bus drive
    // ------------------------------------------------------------------
    logic [RESULT_W-1:0] latch_q;
    logic read_held_q;
    // a toggled read freezes the latch so a word never changes mid-read;
    // a read already held when the conversion began is auto read and refreshes
    wire read_on = cs_s && rd_s;
    wire latch_free = !read_on || read_held_q;
    wire fifo_pop = fifo_out_valid && latch_free;
    wire [RESULT_W-1:0] lanes = half_s ? {latch_q[HALF_W-1:0], LANE_ONES} : latch_q;

    sar_result_fifo #(
        .WIDTH(RESULT_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .ref_clk_in(ref_clk_in),
        .resetn_in(resetn_in),
        .in_valid_in(fifo_push),
        .in_ready_out(fifo_in_ready),
        .in_data_in(hold_q),
        .out_valid_out(fifo_out_valid),
        .out_ready_in(latch_free),
        .out_data_out(fifo_out_data)
    );

    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            latch_q <= RESULT_RESET;
            read_held_q <= 1'b0;
            result_bus_out <= RESULT_RESET;
            result_bus_oe_out <= 1'b0;
        end else begin
            read_held_q <= read_on && (start || read_held_q);
            if (fifo_pop) begin
                latch_q <= fifo_out_data;
            end
            result_bus_out <= lanes;
            result_bus_oe_out <= read_on;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!resetn_in);

    busy_length_a: assert property ($rose(busy_out) |-> ##25 busy_out ##1 !busy_out)
        else $error("busy width differs from conversion time");
    acq_gap_a: assert property ($fell(busy_out) |-> !busy_out [*6])
        else $error("conversion started inside acquisition time");
    start_busy_a: assert property (start |=> busy_out)
        else $error("busy did not rise after convert start");
    bus_release_a: assert property (cs_n_in [*4] |-> !result_bus_oe_out)
        else $error("bus driven while chip select high");
    bus_drive_a: assert property ((!cs_n_in && !rd_n_in) [*4] |-> result_bus_oe_out)
        else $error("bus not driven during read");
    half_lanes_a: assert property ($past(half_s) |->
        result_bus_out == {$past(latch_q[HALF_W-1:0]), LANE_ONES})
        else $error("half select lane mapping wrong");
    sample_hold_a: assert property ((state_q == ST_CONV) &&
        $past(state_q == ST_CONV) |-> $stable(hold_q))
        else $error("held sample changed during conversion");
    reset_clear_a: assert property ($past(!resetn_in) |->
        !busy_out && !result_bus_oe_out && result_bus_out == RESULT_RESET)
        else $error("outputs not cleared by reset");

    conv_done_c: cover property ($fell(busy_out));
    auto_read_c: cover property (result_bus_oe_out && fifo_push);
    half_read_c: cover property (result_bus_oe_out && $past(half_s));
    fifo_full_c: cover property (!fifo_in_ready);
endmodule

`default_nettype wire

// ---- sar_pkg.sv ----
package sar_pkg;
    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int CONV_TIME_NS = 650;
    localparam int ACQ_TIME_NS = 150;
    // longest time rounds down, least time rounds up
    localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
    localparam int ACQ_CYCLES = (ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 5;

    // ------------------------------------------------------------------
    // data layout
    // ------------------------------------------------------------------
    localparam int RESULT_W = 16;
    localparam int HALF_W = 8;
    localparam int FIFO_DEPTH = 16;
    localparam logic [RESULT_W-1:0] RESULT_RESET = 16'h0000;
    localparam logic [HALF_W-1:0] LANE_ONES = 8'hff;

    // ------------------------------------------------------------------
    // conversion sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CONV = 3'b010,
        ST_ACQ = 3'b100
    } conv_state_t;
endpackage

// ---- sar_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// host side: select, read, start, half select and the sample stand-in
// ----------------------------------------------------------------------
module sar_host_model (
    input wire logic ref_clk_in,
    input wire logic busy_in,
    output logic cs_n_out,
    output logic rd_n_out,
    output logic convert_start_n_out,
    output logic half_sel_out,
    output logic [sar_pkg::RESULT_W-1:0] sample_out
);
    import sar_pkg::*;
    initial begin
        cs_n_out = 1'b1;
        rd_n_out = 1'b1;
        convert_start_n_out = 1'b1;
        half_sel_out = 1'b0;
        sample_out = 16'h0000;
    end
    // pins always move 2 ns after the edge, so no sampling race
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_in);
        #2;
    endtask
    task automatic pins(input logic cs_n, input logic rd_n, input logic half);
        cs_n_out = cs_n;
        rd_n_out = rd_n;
        half_sel_out = half;
    endtask
    task automatic pulse(input logic [RESULT_W-1:0] sample);
        sample_out = sample;
        convert_start_n_out = 1'b0;
        tick(2);
        convert_start_n_out = 1'b1;
    endtask
    // go low: the start must be refused; ok tells whether it went as asked
    task automatic convert(input logic [RESULT_W-1:0] sample, input logic go, output logic ok);
        int i;
        pulse(sample);
        for (i = 0; i < 10 && !busy_in; i++) tick(1);
        ok = (busy_in === go);
        // the input moves while held, so a live sample would show up
        sample_out = ~sample;
        for (i = 0; i < 40 && busy_in; i++) tick(1);
        ok = ok && !busy_in;
        tick(ACQ_CYCLES + 2);
    endtask
endmodule
`default_nettype wire

// ---- sar_adc_conversion_readout_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module sar_adc_conversion_readout_test;
    import sar_pkg::*;
    logic ref_clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic cs_n, rd_n, convert_start_n, half_sel, busy, oe, ok;
    logic oe_prev = 1'b0;
    logic [RESULT_W-1:0] sample, bus, s;
    logic [RESULT_W-1:0] bus_prev = '0;
    logic [RESULT_W-1:0] expq[$];
    int n_mismatch = 0, checks_done = 0, busy_len = 0, i;
    integer seed = 32'h4b9a;
    always #12.5 ref_clk_in = ~ref_clk_in;
    sar_adc_readout u_sar_adc_readout (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
        .cs_n_in(cs_n), .rd_n_in(rd_n), .convert_start_n_in(convert_start_n),
        .half_sel_in(half_sel), .sample_in(sample), .busy_out(busy),
        .result_bus_out(bus), .result_bus_oe_out(oe));
    sar_host_model u_sar_host_model (.ref_clk_in(ref_clk_in), .busy_in(busy),
        .cs_n_out(cs_n), .rd_n_out(rd_n), .convert_start_n_out(convert_start_n),
        .half_sel_out(half_sel), .sample_out(sample));
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (exp !== got) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ------------------------------------------------------------------
    // watcher: each new word on an enabled bus takes the oldest note
    // ------------------------------------------------------------------
    always @(posedge ref_clk_in) begin
        if (oe === 1'b1 && (oe_prev !== 1'b1 || bus !== bus_prev)) begin
            check("bus word", expq.size() > 0 ? expq.pop_front() : 16'hxxxx, bus);
        end
        oe_prev = oe;
        bus_prev = bus;
        if (!resetn_in) begin
            busy_len = 0;
        end else if (busy === 1'b1) begin
            busy_len++;
        end else if (busy_len != 0) begin
            check("busy cycles", 16'(CONV_CYCLES), 16'(busy_len));
            busy_len = 0;
        end
    end
    task automatic tk(input int n);
        u_sar_host_model.tick(n);
    endtask
    task automatic conv(input logic [RESULT_W-1:0] w, input logic go);
        u_sar_host_model.convert(w, go, ok);
        check("start outcome", 16'h0001, 16'(ok));
        if (ok !== 1'b1) results();
    endtask
    // 8-bit host: upper lanes read twice, then the bus must let go
    task automatic read_pair(input logic [RESULT_W-1:0] w);
        expq.push_back(w);
        expq.push_back({w[7:0], LANE_ONES});
        u_sar_host_model.pins(1'b0, 1'b0, 1'b0);
        tk(5);
        u_sar_host_model.pins(1'b0, 1'b0, 1'b1);
        tk(5);
        u_sar_host_model.pins(1'b1, 1'b0, 1'b0);
        tk(5);
        check("bus enable", 16'h0000, 16'(oe));
        u_sar_host_model.pins(1'b0, 1'b1, 1'b0);
        tk(5);
        check("bus enable", 16'h0000, 16'(oe));
    endtask
    initial begin
        #(25 * 100000);
        check("watchdog", 16'h0000, 16'h0001);
        results();
    end
    initial begin
        repeat (12) @(posedge ref_clk_in);
        #2 resetn_in = 1'b1;
        tk(8);
        read_pair(16'h0000);
        for (i = 0; i < 4; i++) begin
            s = 16'($random(seed)) | 16'h0001;
            u_sar_host_model.pins(1'b0, 1'b1, 1'b0);
            conv(s, 1'b1);
            read_pair(s);
        end
        u_sar_host_model.pins(1'b1, 1'b1, 1'b0);
        conv(16'h1234, 1'b0);
        // both pins tied low: every finished conversion reaches the bus
        expq.push_back(s);
        u_sar_host_model.pins(1'b0, 1'b0, 1'b0);
        for (i = 0; i < 3; i++) begin
            s = 16'($random(seed)) | 16'h0001;
            expq.push_back(s);
            conv(s, 1'b1);
        end
        // abort mid-conversion by reset, with select high
        u_sar_host_model.pins(1'b0, 1'b1, 1'b0);
        u_sar_host_model.pulse(16'h5a5a);
        tk(10);
        u_sar_host_model.pins(1'b1, 1'b1, 1'b0);
        resetn_in = 1'b0;
        tk(2);
        check("busy in reset", 16'h0000, 16'(busy));
        check("enable in reset", 16'h0000, 16'(oe));
        resetn_in = 1'b1;
        tk(8);
        read_pair(16'h0000);
        check("notes left", 16'h0000, 16'(expq.size()));
        results();
    end
endmodule
`default_nettype wire
